// *** verilog/cwfp_defines.svh ***
`ifndef CWFP_DEFINES_SVH
`define CWFP_DEFINES_SVH

// Register offsets on the seven-bit register address.
`define CWFP_ADDR_LEN_CFG 7'h37
`define CWFP_ADDR_PAY_7_6 7'h38
`define CWFP_ADDR_PAY_3_2 7'h39
`define CWFP_ADDR_PAY_5_4 7'h3A
`define CWFP_ADDR_PAY_1_0 7'h3B
`define CWFP_ADDR_FD_CFG 7'h3C

// Field positions of the tolerance configuration register and the length code MSB.
`define CWFP_FD_ERRDIS_BIT 5
`define CWFP_FD_FILT_MSB 3
`define CWFP_FD_FILT_LSB 1
`define CWFP_FD_EN_BIT 0
`define CWFP_LEN_MSB 3

// Reset values, writable bits and bits that survive a restart.
`define CWFP_RESET_VALUE 16'h0000
`define CWFP_LEN_WR_MASK 16'h000F
`define CWFP_FD_WR_MASK 16'h002F
`define CWFP_LEN_RESTART_KEEP 16'h000F
`define CWFP_FD_RESTART_KEEP 16'h002F

// Dominant filter timing.
`define CWFP_CLK_PERIOD_NS 20
`define CWFP_FILT_STEP_NS 50
`define CWFP_FILT_LONG_NS 775
`define CWFP_FILT_LONG_CODE 3'h7

`endif

// *** verilog/cwfp_pkg.sv ***
package cwfp_pkg;

   // One-hot register select from the address decode.
   typedef enum logic [6:0] {
      CWFP_SEL_NONE = 7'h01,
      CWFP_SEL_LEN = 7'h02,
      CWFP_SEL_P10 = 7'h04,
      CWFP_SEL_P32 = 7'h08,
      CWFP_SEL_P54 = 7'h10,
      CWFP_SEL_P76 = 7'h20,
      CWFP_SEL_FD = 7'h40
   } cwfp_sel_e;

   typedef struct packed {
      logic [6:0] addr;
      logic wr;
      logic rd;
      logic [15:0] wdata;
   } cwfp_req_s;

   typedef struct packed {
      logic valid;
      logic [3:0] dlc;
      logic [63:0] data;
   } cwfp_frame_s;

   typedef struct packed {
      logic [3:0] len_code;
      logic [3:0][15:0] payload;
      logic err_dis;
      logic [2:0] filt;
      logic fd_en;
      logic [15:0] rdata;
      logic match;
      logic checked;
      logic [5:0] filt_cycles;
   } cwfp_state_s;

endpackage

// *** verilog/cwfp_payload_cmp.sv ***
`timescale 1ns/1ps
module cwfp_payload_cmp (
   // Configured expectation
   input wire logic [3:0] cfg_len,
   input wire logic [63:0] exp_data,
   // Received frame
   input wire logic [3:0] rx_len,
   input wire logic [63:0] rx_data,
   // Verdict
   output logic match
);

   // Codes eight to fifteen all mean eight bytes.
   function automatic logic [3:0] cwfp_byte_count(input logic [3:0] code);
      cwfp_byte_count = code[3] ? 4'h8 : code;
   endfunction

   logic [3:0] nbytes;
   logic data_ok;

   always_comb begin
      nbytes = cwfp_byte_count(cfg_len);
      data_ok = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < nbytes && rx_data[8*i +: 8] != exp_data[8*i +: 8]) begin
            data_ok = 1'b0;
         end
      end
      // The raw code is compared, so 8 and 15 do not match each other.
      match = (rx_len == cfg_len) && data_ok;
   end

endmodule

// *** verilog/cwfp_wake_payload.sv ***
`timescale 1ns/1ps
`include "cwfp_defines.svh"

////////////////////////////////////////////////////////////////////////////////

// How it works
// - A length code of 0 to 7 means that many bytes and any code of 8 to 15 means eight bytes.
// - A frame qualifies only if its four-bit length code equals the stored code bit for bit.
// - Each payload register holds the odd byte in bits 15:8 and the even byte in bits 7:0, bit 0 least significant.
// - Reserved bits of every register read as zero.
// - Restart clears the upper twelve length bits and keeps the code; power-on or soft reset clears it all.
// - Restart keeps bit 5 and bits 3:0 of the tolerance register; power-on or soft reset clears it all.
// - The error counter runs unless the disable bit and the tolerant enable are both set.
// - Expiry of the bus silence timeout clears the error counter disable bit in hardware.
// - Filter code 0 to 6 selects 50 ns to 350 ns in 50 ns steps and code 7 selects 775 ns.
// - Bit 0 of the tolerance register enables tolerant mode when set.
// - Receiver select 0 picks the low-power receiver and 1 the standard receiver.
module cwfp_wake_payload (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register access
   input wire cwfp_pkg::cwfp_req_s req,
   output logic [15:0] reg_rdata,
   // Reset sources besides power-on
   input wire logic soft_reset,
   input wire logic restart,
   // Bus events
   input wire logic silence_expired,
   input wire cwfp_pkg::cwfp_frame_s frame,
   // Receiver choice from the trim register
   input wire logic wake_receiver_select,
   // Results
   output logic frame_match,
   output logic frame_checked,
   output logic error_counter_run,
   output logic fd_tolerant_enable,
   output logic low_power_receiver,
   output logic [5:0] dominant_filter_cycles
);

   ////////////////////////////////////////////////////////////////////////////////

   cwfp_pkg::cwfp_state_s state_reg;
   cwfp_pkg::cwfp_state_s state_next;
   cwfp_pkg::cwfp_sel_e sel;
   logic cmp_match;

   // Least time rounds up to whole clock cycles.
   function automatic logic [5:0] cwfp_filter_cycles(input logic [2:0] code);
      int ns;
      ns = (code == `CWFP_FILT_LONG_CODE) ? `CWFP_FILT_LONG_NS
         : `CWFP_FILT_STEP_NS * (int'(code) + 1);
      cwfp_filter_cycles = 6'((ns + `CWFP_CLK_PERIOD_NS - 1) / `CWFP_CLK_PERIOD_NS);
   endfunction

   function automatic logic [15:0] cwfp_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [15:0] mask);
      cwfp_merge = (old & ~mask) | (wd & mask);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      if (req.addr == `CWFP_ADDR_LEN_CFG) begin
         sel = cwfp_pkg::CWFP_SEL_LEN;
      end else if (req.addr == `CWFP_ADDR_PAY_1_0) begin
         sel = cwfp_pkg::CWFP_SEL_P10;
      end else if (req.addr == `CWFP_ADDR_PAY_3_2) begin
         sel = cwfp_pkg::CWFP_SEL_P32;
      end else if (req.addr == `CWFP_ADDR_PAY_5_4) begin
         sel = cwfp_pkg::CWFP_SEL_P54;
      end else if (req.addr == `CWFP_ADDR_PAY_7_6) begin
         sel = cwfp_pkg::CWFP_SEL_P76;
      end else if (req.addr == `CWFP_ADDR_FD_CFG) begin
         sel = cwfp_pkg::CWFP_SEL_FD;
      end else begin
         sel = cwfp_pkg::CWFP_SEL_NONE;
      end
   end

   cwfp_payload_cmp u_cmp (
      .cfg_len(state_reg.len_code),
      .exp_data(state_reg.payload),
      .rx_len(frame.dlc),
      .rx_data(frame.data),
      .match(cmp_match)
   );

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      logic [15:0] fd_word;
      logic [15:0] len_word;
      fd_word = {10'h000, state_reg.err_dis, 1'b0, state_reg.filt, state_reg.fd_en};
      len_word = {12'h000, state_reg.len_code};
      state_next = state_reg;
      state_next.checked = 1'b0;
      // Software writes only reach the writable bits.
      if (req.wr) begin
         case (sel)
            cwfp_pkg::CWFP_SEL_LEN: begin
               len_word = cwfp_merge(len_word, req.wdata, `CWFP_LEN_WR_MASK);
            end
            cwfp_pkg::CWFP_SEL_P10: begin
               state_next.payload[0] = req.wdata;
            end
            cwfp_pkg::CWFP_SEL_P32: begin
               state_next.payload[1] = req.wdata;
            end
            cwfp_pkg::CWFP_SEL_P54: begin
               state_next.payload[2] = req.wdata;
            end
            cwfp_pkg::CWFP_SEL_P76: begin
               state_next.payload[3] = req.wdata;
            end
            cwfp_pkg::CWFP_SEL_FD: begin
               fd_word = cwfp_merge(fd_word, req.wdata, `CWFP_FD_WR_MASK);
            end
            default: begin
            end
         endcase
      end
      // The hardware clear overrides a write in the same cycle.
      if (silence_expired) begin
         fd_word[`CWFP_FD_ERRDIS_BIT] = 1'b0;
      end
      if (restart) begin
         len_word = len_word & `CWFP_LEN_RESTART_KEEP;
         fd_word = fd_word & `CWFP_FD_RESTART_KEEP;
      end
      state_next.len_code = len_word[`CWFP_LEN_MSB:0];
      state_next.err_dis = fd_word[`CWFP_FD_ERRDIS_BIT];
      state_next.filt = fd_word[`CWFP_FD_FILT_MSB:`CWFP_FD_FILT_LSB];
      state_next.fd_en = fd_word[`CWFP_FD_EN_BIT];
      state_next.filt_cycles = cwfp_filter_cycles(state_next.filt);
      // Read data is sampled before any write of the same cycle.
      if (req.rd) begin
         if (sel == cwfp_pkg::CWFP_SEL_LEN) begin
            state_next.rdata = {12'h000, state_reg.len_code};
         end else if (sel == cwfp_pkg::CWFP_SEL_P10) begin
            state_next.rdata = state_reg.payload[0];
         end else if (sel == cwfp_pkg::CWFP_SEL_P32) begin
            state_next.rdata = state_reg.payload[1];
         end else if (sel == cwfp_pkg::CWFP_SEL_P54) begin
            state_next.rdata = state_reg.payload[2];
         end else if (sel == cwfp_pkg::CWFP_SEL_P76) begin
            state_next.rdata = state_reg.payload[3];
         end else if (sel == cwfp_pkg::CWFP_SEL_FD) begin
            state_next.rdata = {10'h000, state_reg.err_dis, 1'b0, state_reg.filt, state_reg.fd_en};
         end else begin
            state_next.rdata = 16'h0000;
         end
      end
      if (frame.valid) begin
         state_next.match = cmp_match;
         state_next.checked = 1'b1;
      end
      // A soft reset behaves as power-on for these registers.
      if (soft_reset) begin
         state_next = '0;
         state_next.filt_cycles = cwfp_filter_cycles(3'h0);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.filt_cycles <= 6'h03;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   assign reg_rdata = state_reg.rdata;
   assign frame_match = state_reg.match;
   assign frame_checked = state_reg.checked;
   assign fd_tolerant_enable = state_reg.fd_en;
   assign error_counter_run = !(state_reg.err_dis && state_reg.fd_en);
   assign low_power_receiver = !wake_receiver_select;
   assign dominant_filter_cycles = state_reg.filt_cycles;

   ////////////////////////////////////////////////////////////////////////////////

   sequence s_fd_write(logic [15:0] wd);
      req.wr && sel == cwfp_pkg::CWFP_SEL_FD && req.wdata == wd;
   endsequence

   sequence s_quiet;
      !soft_reset && !restart && !silence_expired;
   endsequence

   sequence s_frame_in;
      frame.valid && !soft_reset;
   endsequence

   sequence s_verdict(logic v);
      frame_checked && frame_match == v;
   endsequence

   chk_len_restart: assert property (@(posedge clock) disable iff (!reset_n)
      restart && !soft_reset && !(req.wr && sel == cwfp_pkg::CWFP_SEL_LEN)
      |=> state_reg.len_code == $past(state_reg.len_code))
      else $error("Length code lost on restart.");

   chk_fd_restart: assert property (@(posedge clock) disable iff (!reset_n)
      restart && !soft_reset && !silence_expired && !req.wr
      |=> {state_reg.err_dis, state_reg.filt, state_reg.fd_en}
          == $past({state_reg.err_dis, state_reg.filt, state_reg.fd_en}))
      else $error("Tolerance bits lost on restart.");

   chk_soft_clear: assert property (@(posedge clock) disable iff (!reset_n)
      soft_reset |=> state_reg.len_code == 4'h0 && state_reg.payload == 64'h0 && !state_reg.fd_en)
      else $error("Soft reset did not clear registers.");

   chk_silence_clear: assert property (@(posedge clock) disable iff (!reset_n)
      silence_expired |=> !state_reg.err_dis)
      else $error("Disable bit survived silence timeout.");

   chk_errcnt_gate: assert property (@(posedge clock) disable iff (!reset_n)
      s_quiet ##0 s_fd_write(16'h0021) |=> !error_counter_run && state_reg.err_dis && state_reg.fd_en)
      else $error("Error counter gating wrong.");

   chk_errcnt_free: assert property (@(posedge clock) disable iff (!reset_n)
      !fd_tolerant_enable |-> error_counter_run)
      else $error("Error counter stopped without tolerant mode.");

   chk_tolerant_write: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && sel == cwfp_pkg::CWFP_SEL_FD && !soft_reset |=> fd_tolerant_enable == $past(req.wdata[0]))
      else $error("Tolerant enable not written.");

   chk_filter_long: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.filt == 3'h7 |-> dominant_filter_cycles == 6'h27)
      else $error("Long filter time wrong.");

   chk_filter_mid: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.filt == 3'h6 |-> dominant_filter_cycles == 6'h12)
      else $error("Filter time for code six wrong.");

   chk_filter_short: assert property (@(posedge clock) disable iff (!reset_n)
      state_reg.filt == 3'h0 |-> dominant_filter_cycles == 6'h03)
      else $error("Short filter time wrong.");

   chk_reserved_zero: assert property (@(posedge clock) disable iff (!reset_n)
      req.rd && sel == cwfp_pkg::CWFP_SEL_FD && !soft_reset |=> reg_rdata[15:6] == 10'h000 && !reg_rdata[4])
      else $error("Reserved bits read non-zero.");

   chk_len_read: assert property (@(posedge clock) disable iff (!reset_n)
      req.rd && sel == cwfp_pkg::CWFP_SEL_LEN && !soft_reset |=> reg_rdata[15:4] == 12'h000)
      else $error("Reserved length bits read non-zero.");

   chk_unmapped_read: assert property (@(posedge clock) disable iff (!reset_n)
      req.rd && sel == cwfp_pkg::CWFP_SEL_NONE |=> reg_rdata == 16'h0000)
      else $error("Unmapped address read non-zero.");

   chk_read_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !req.rd && !soft_reset |=> $stable(reg_rdata))
      else $error("Read data changed without read.");

   chk_payload_low: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && sel == cwfp_pkg::CWFP_SEL_P10 && !soft_reset |=> state_reg.payload[0] == $past(req.wdata))
      else $error("Bytes one and zero not stored.");

   chk_payload_high: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && sel == cwfp_pkg::CWFP_SEL_P76 && !soft_reset |=> state_reg.payload[3] == $past(req.wdata))
      else $error("Bytes seven and six not stored.");

   chk_reserved_write: assert property (@(posedge clock) disable iff (!reset_n)
      req.wr && sel == cwfp_pkg::CWFP_SEL_LEN && !soft_reset && !restart
      |=> state_reg.len_code == $past(req.wdata[3:0]))
      else $error("Length write wrong.");

   chk_len_mismatch: assert property (@(posedge clock) disable iff (!reset_n)
      frame.valid && !soft_reset && frame.dlc != state_reg.len_code |=> frame_checked && !frame_match)
      else $error("Frame with other length code matched.");

   chk_frame_equal: assert property (@(posedge clock) disable iff (!reset_n)
      s_frame_in ##0 (frame.dlc == state_reg.len_code && frame.data == state_reg.payload) |=> s_verdict(1'b1))
      else $error("Identical frame did not match.");

   chk_empty_frame: assert property (@(posedge clock) disable iff (!reset_n)
      s_frame_in ##0 (frame.dlc == state_reg.len_code && state_reg.len_code == 4'h0) |=> s_verdict(1'b1))
      else $error("Zero length frame did not match.");

   chk_long_frame: assert property (@(posedge clock) disable iff (!reset_n)
      s_frame_in ##0 (state_reg.len_code[3] && frame.data != state_reg.payload) |=> s_verdict(1'b0))
      else $error("Eight byte frame with other data matched.");

   chk_checked_idle: assert property (@(posedge clock) disable iff (!reset_n)
      !frame.valid |=> !frame_checked)
      else $error("Verdict strobe without frame.");

   chk_match_hold: assert property (@(posedge clock) disable iff (!reset_n)
      !frame.valid && !soft_reset |=> $stable(frame_match))
      else $error("Verdict changed without frame.");

   chk_receiver_sel: assert property (@(posedge clock) disable iff (!reset_n)
      low_power_receiver != wake_receiver_select)
      else $error("Receiver select inverted.");

endmodule

// *** testbench/cwfp_frame_source.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module cwfp_frame_source (
   // Clock
   input wire logic clock,
   // Frame request from the bench
   input wire logic send,
   input wire logic [3:0] dlc,
   input wire logic [63:0] data,
   // Received frame toward the block
   output cwfp_pkg::cwfp_frame_s frame
);
   initial frame = '0;

   // Between frames the fields are inverted every cycle, so a stale payload can never pass for a fresh one.
   always @(posedge clock) begin
      if (send) begin
         frame <= '{1'b1, dlc, data};
      end else begin
         frame <= '{1'b0, ~frame.dlc, ~frame.data};
      end
   end
endmodule

// *** testbench/cwfp_wake_payload_test.sv ***
`timescale 1ns/1ps
`include "cwfp_defines.svh"

////////////////////////////////////////////////////////////////////////////////

module cwfp_wake_payload_test;
   localparam logic [6:0] A_LEN = `CWFP_ADDR_LEN_CFG;
   localparam logic [6:0] A_FD = `CWFP_ADDR_FD_CFG;
   localparam int P_SILENCE = 0;
   localparam int P_RESTART = 1;
   localparam int P_SOFT = 2;
   localparam logic [6:0] ADDRS [6] = '{A_LEN, `CWFP_ADDR_PAY_1_0, `CWFP_ADDR_PAY_3_2,
      `CWFP_ADDR_PAY_5_4, `CWFP_ADDR_PAY_7_6, A_FD};
   localparam logic [15:0] MASKS [6] = '{16'h000F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h002F};
   localparam logic [15:0] PAYS [4] = '{16'hA1A0, 16'hA3A2, 16'hA5A4, 16'hA7A6};
   localparam logic [63:0] PAY = 64'hA7A6A5A4A3A2A1A0;
   // Filter time in 20 ns cycles, rounded up.
   localparam logic [5:0] FILT [8] = '{6'h03, 6'h05, 6'h08, 6'h0A, 6'h0D, 6'h0F, 6'h12, 6'h27};
   // Each entry: stored code, frame code, corrupted byte (8 for none), expected verdict.
   localparam logic [15:0] CASES [9] = '{16'h2281, 16'h2221, 16'h2210, 16'h8F80, 16'hCC70,
      16'hCC81, 16'h0001, 16'h7760, 16'h7771};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   cwfp_pkg::cwfp_req_s req = '0;
   logic soft_reset = 1'b0;
   logic restart = 1'b0;
   logic silence_expired = 1'b0;
   logic wake_receiver_select = 1'b0;
   logic send = 1'b0;
   logic [3:0] send_dlc = 4'h0;
   logic [63:0] send_data = 64'h0;
   cwfp_pkg::cwfp_frame_s frame;
   logic [15:0] reg_rdata;
   logic frame_match, frame_checked, error_counter_run, fd_tolerant_enable, low_power_receiver;
   logic [5:0] dominant_filter_cycles;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;

   cwfp_frame_source partner (.clock(clock), .send(send), .dlc(send_dlc), .data(send_data), .frame(frame));

   cwfp_wake_payload dut (.clock(clock), .reset_n(reset_n), .req(req), .reg_rdata(reg_rdata),
      .soft_reset(soft_reset), .restart(restart), .silence_expired(silence_expired), .frame(frame),
      .wake_receiver_select(wake_receiver_select), .frame_match(frame_match), .frame_checked(frame_checked),
      .error_counter_run(error_counter_run), .fd_tolerant_enable(fd_tolerant_enable),
      .low_power_receiver(low_power_receiver), .dominant_filter_cycles(dominant_filter_cycles));

   ////////////////////////////////////////////////////////////////////////////////

   always #10 clock = ~clock;

   // The whole sequence needs well under a thousand cycles.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check1(input logic got, input logic exp, input string what);
      check({15'h0, got}, {15'h0, exp}, what);
   endtask

   task automatic cycle();
      @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      cycle();
      req = '{a, 1'b1, 1'b0, d};
      cycle();
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string what);
      cycle();
      req = '{a, 1'b0, 1'b1, 16'h0};
      cycle();
      req.rd = 1'b0;
      check(reg_rdata, exp, what);
   endtask

   task automatic pulse(input int which);
      cycle();
      silence_expired = (which == P_SILENCE);
      restart = (which == P_RESTART);
      soft_reset = (which == P_SOFT);
      cycle();
      silence_expired = 1'b0;
      restart = 1'b0;
      soft_reset = 1'b0;
   endtask

   task automatic send_frame(input logic [3:0] d, input logic [63:0] x, input logic exp);
      cycle();
      send = 1'b1;
      send_dlc = d;
      send_data = x;
      cycle();
      send = 1'b0;
      cycle();
      check1(frame_checked, 1'b1, "frame checked");
      check1(frame_match, exp, "frame verdict");
      cycle();
      check1(frame_checked, 1'b0, "checked pulse");
   endtask

   ////////////////////////////////////////////////////////////////////////////////

   initial begin
      repeat (20) @(posedge clock);
      #1 reset_n = 1'b1;
      for (int i = 0; i < 6; i++) rd(ADDRS[i], 16'h0000, "reset value");
      check1(error_counter_run, 1'b1, "counter after reset");
      check({10'h0, dominant_filter_cycles}, 16'h0003, "filter after reset");
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wr(ADDRS[i], 16'hFFFF);
         rd(ADDRS[i], MASKS[i], "writable bits");
      end
      wr(7'h40, 16'hFFFF);
      rd(7'h40, 16'h0000, "unmapped");
      $display("test access done");
      for (int c = 0; c < 8; c++) begin
         wr(A_FD, {12'h0, c[2:0], 1'b0});
         cycle();
         check({10'h0, dominant_filter_cycles}, {10'h0, FILT[c]}, "filter time");
      end
      $display("test filter done");
      wr(A_FD, 16'h0020);
      cycle();
      check1(error_counter_run, 1'b1, "disable alone");
      check1(fd_tolerant_enable, 1'b0, "tolerant off");
      wr(A_FD, 16'h0021);
      cycle();
      check1(error_counter_run, 1'b0, "disable with tolerant");
      check1(fd_tolerant_enable, 1'b1, "tolerant on");
      pulse(P_SILENCE);
      rd(A_FD, 16'h0001, "silence clears disable");
      check1(error_counter_run, 1'b1, "counter runs again");
      // The timeout and a software write land on one edge; the hardware clear must win.
      silence_expired = 1'b1;
      wr(A_FD, 16'h0021);
      silence_expired = 1'b0;
      rd(A_FD, 16'h0001, "clear beats write");
      $display("test tolerance done");
      // The standard receiver is picked first, as fast tolerant traffic needs.
      wake_receiver_select = 1'b1;
      cycle();
      check1(low_power_receiver, 1'b0, "standard receiver");
      wake_receiver_select = 1'b0;
      cycle();
      check1(low_power_receiver, 1'b1, "low power receiver");
      $display("test receiver done");
      for (int i = 0; i < 4; i++) wr(ADDRS[i + 1], PAYS[i]);
      for (int k = 0; k < 9; k++) begin
         logic [63:0] rx;
         rx = (CASES[k][7:4] == 4'h8) ? PAY : (PAY ^ (64'h1 << (8 * CASES[k][7:4])));
         wr(A_LEN, {12'h0, CASES[k][15:12]});
         send_frame(CASES[k][11:8], rx, CASES[k][0]);
      end
      $display("test frames done");
      wr(A_LEN, 16'h000C);
      wr(A_FD, 16'h002F);
      pulse(P_RESTART);
      rd(A_LEN, 16'h000C, "restart length");
      rd(A_FD, 16'h002F, "restart tolerance");
      rd(ADDRS[4], PAYS[3], "restart payload");
      pulse(P_SOFT);
      for (int i = 0; i < 6; i++) rd(ADDRS[i], 16'h0000, "soft reset");
      wr(ADDRS[1], 16'h1234);
      reset_n = 1'b0;
      cycle();
      reset_n = 1'b1;
      rd(ADDRS[1], 16'h0000, "power-on clear");
      $display("test resets done");
      end_of_test();
   end
endmodule
